/* File: timer16_pwm_pkg.sv */
package timer16_pwm_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses on the bus)
    // ----------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFS    = 8'h00;
    localparam logic [7:0]  CMPA_OFS    = 8'h04;
    localparam logic [7:0]  CMPB_OFS    = 8'h08;
    localparam logic [7:0]  CAPTOP_OFS  = 8'h0c;
    localparam logic [7:0]  COUNT_OFS   = 8'h10;
    localparam logic [7:0]  STATUS_OFS  = 8'h14;

    // ----------------------------------------------------------------
    // waveform mode codes and compare output actions
    // ----------------------------------------------------------------
    localparam logic [3:0]  MODE_PC8    = 4'h1;
    localparam logic [3:0]  MODE_PC9    = 4'h2;
    localparam logic [3:0]  MODE_PC10   = 4'h3;
    localparam logic [3:0]  MODE_FAST8  = 4'h5;
    localparam logic [3:0]  MODE_FAST9  = 4'h6;
    localparam logic [3:0]  MODE_FAST10 = 4'h7;
    localparam logic [3:0]  MODE_PCCAP  = 4'ha;
    localparam logic [3:0]  MODE_PCCMPA = 4'hb;
    localparam logic [3:0]  MODE_FASTCAP  = 4'he;
    localparam logic [3:0]  MODE_FASTCMPA = 4'hf;

    localparam logic [1:0]  COM_OFF     = 2'h0;
    localparam logic [1:0]  COM_TOGGLE  = 2'h1;
    localparam logic [1:0]  COM_NONINV  = 2'h2;
    localparam logic [1:0]  COM_INV     = 2'h3;

    // ----------------------------------------------------------------
    // fixed tops, counter constants, prescaler
    // ----------------------------------------------------------------
    localparam logic [15:0] TOP_8BIT    = 16'h00ff;
    localparam logic [15:0] TOP_9BIT    = 16'h01ff;
    localparam logic [15:0] TOP_10BIT   = 16'h03ff;
    localparam logic [15:0] TOP_FULL    = 16'hffff;
    localparam logic [15:0] CNT_BOTTOM  = 16'h0000;
    localparam logic [15:0] CNT_STEP    = 16'h0001;

    localparam logic [2:0]  CS_STOP     = 3'h0;
    localparam logic [2:0]  CS_DIV1     = 3'h1;
    localparam logic [2:0]  CS_DIV8     = 3'h2;
    localparam logic [2:0]  CS_DIV64    = 3'h3;
    localparam logic [2:0]  CS_DIV256   = 3'h4;
    localparam logic [2:0]  CS_DIV1024  = 3'h5;
    localparam logic [9:0]  PRE_MASK8   = 10'h007;
    localparam logic [9:0]  PRE_MASK64  = 10'h03f;
    localparam logic [9:0]  PRE_MASK256 = 10'h0ff;
    localparam logic [9:0]  PRE_MASK1024 = 10'h3ff;
    localparam logic [9:0]  PRE_STEP    = 10'h001;

    // ----------------------------------------------------------------
    // status bit positions, control layout
    // ----------------------------------------------------------------
    localparam int          ST_OVF      = 0;
    localparam int          ST_CMPA     = 1;
    localparam int          ST_CMPB     = 2;
    localparam int          ST_CAP      = 3;
    localparam int          ST_OUTA     = 8;
    localparam int          ST_OUTB     = 9;
    localparam int          CTRL_W      = 11;

    typedef struct packed {
        logic [2:0] clkSel;
        logic [1:0] comB;
        logic [1:0] comA;
        logic [3:0] mode;
    } ctrl_s;

    localparam ctrl_s       CTRL_RESET  = '0;

endpackage : timer16_pwm_pkg

/* File: timer16_fast_phase_pwm.sv */
`timescale 1ns/1ps
// What this block does
// - fast modes count zero up to TOP, repeat
// - fast TOP: fixed 8/9/10 bit, capture, compareA
// - counter at TOP clears on next tick
// - fast: clear on match, set at bottom
// - output mode 2 non-inverted, 3 inverted
// - fast overflow at TOP, plus TOP-register flag
// - match flag on a PWM-mode tick that counter equals compare
// - fixed TOP masks high compare write bits
// - capture-top unbuffered; missed TOP wraps through 0xffff
// - fast compareA buffered, loaded at TOP clear
// - compare zero spikes, compare TOP constant
// - fast mode 15 toggle gives square wave on output A only; B does not toggle
// - phase modes 1,2,3 fixed; 10,11 registers
// - phase: up to TOP, turn without hold, down
// - phase: clear up-match, set down-match
// - phase overflow flag at bottom
// - phase buffers load at TOP, flag too
// - phase compare zero low, TOP high
// - phase mode 11 toggle gives square wave on output A only; B does not toggle
// - prescaler divides by 1,8,64,256,1024
// - reset clears compare output states
// - output mode zero leaves state unchanged
module timer16_fast_phase_pwm
    import timer16_pwm_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             compareOutputA,
    output logic             compareOutputB,
    output logic             pinOverrideA,
    output logic             pinOverrideB
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    ctrl_s       ctrl_r;
    logic [15:0] cnt_r;
    logic        dirUp_r;
    logic [9:0]  pre_r;
    logic [15:0] ocrABuf_r;
    logic [15:0] ocrBBuf_r;
    logic [15:0] ocrAAct_r;
    logic [15:0] ocrBAct_r;
    logic [15:0] capTop_r;
    logic [3:0]  flags_r;
    logic        outA_r;
    logic        outB_r;
    logic        ack_r;
    logic [31:0] rdat_r;
    logic        ovrA_r;
    logic        ovrB_r;

    logic        access;
    logic        wrEn;
    logic        isFast;
    logic        isPc;
    logic        tick;
    logic [15:0] fixMask;
    logic [15:0] topVal;
    logic        atTop;
    logic        atBot;
    logic        matchA;
    logic        matchB;
    logic        loadPt;
    logic        topIsA;
    logic        topIsCap;
    logic [15:0] ctrlMerged;
    logic [3:0]  flagSet;
    logic [3:0]  flagClr;

    // keeps unselected byte lanes of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
        return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // next compare output state for one channel
    function automatic logic nextOut(input logic cur, input logic [1:0] com, input logic match,
                                     input logic toggleOk, input logic fast, input logic pc,
                                     input logic top, input logic bot, input logic up);
        logic res;
        logic lvl;
        res = cur;
        lvl = 1'b0;
        if (com == COM_TOGGLE)
        begin
            if (toggleOk && match)
                res = ~cur;
        end
        else if (com[1])
        begin
            if (fast)
            begin
                // bottom set wins over a match at TOP: compare==TOP stays constant
                if (top)
                    res = (com == COM_NONINV);
                else if (match)
                    res = (com == COM_INV);
            end
            else if (pc && match)
            begin
                // a match at bottom counts as upward, at TOP as downward
                lvl = top || (!up && !bot);
                res = (com == COM_NONINV) ? lvl : ~lvl;
            end
        end
        return res;
    endfunction : nextOut

    // ----------------------------------------------------------------
    // mode decode and top selection
    // ----------------------------------------------------------------
    assign access   = wb_cyc_i && wb_stb_i && !ack_r;
    assign wrEn     = access && wb_we_i;
    assign ctrlMerged = merge16({5'h00, ctrl_r}, wb_dat_i, wb_sel_i);

    always_comb
    begin
        isFast  = ctrl_r.mode inside {MODE_FAST8, MODE_FAST9, MODE_FAST10, MODE_FASTCAP, MODE_FASTCMPA};
        isPc    = ctrl_r.mode inside {MODE_PC8, MODE_PC9, MODE_PC10, MODE_PCCAP, MODE_PCCMPA};
        topIsA  = (ctrl_r.mode == MODE_FASTCMPA) || (ctrl_r.mode == MODE_PCCMPA);
        topIsCap = (ctrl_r.mode == MODE_FASTCAP) || (ctrl_r.mode == MODE_PCCAP);
        unique case (ctrl_r.mode)
            MODE_FAST8, MODE_PC8:   fixMask = TOP_8BIT;
            MODE_FAST9, MODE_PC9:   fixMask = TOP_9BIT;
            MODE_FAST10, MODE_PC10: fixMask = TOP_10BIT;
            default:                fixMask = TOP_FULL;
        endcase
        // capture-top is used straight, no buffer in between
        if (topIsCap)
            topVal = capTop_r;
        else if (topIsA)
            topVal = ocrAAct_r;
        else
            topVal = fixMask;
    end

    assign atTop  = (cnt_r == topVal);
    assign atBot  = (cnt_r == CNT_BOTTOM);
    assign matchA = (cnt_r == ocrAAct_r);
    assign matchB = (cnt_r == ocrBAct_r);
    assign loadPt = tick && atTop && (isFast || isPc);

    // ----------------------------------------------------------------
    // prescaler: timer tick as a clock enable
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
            pre_r <= '0;
        else
            pre_r <= pre_r + PRE_STEP;
    end

    // a shared free-running divider; a new select may give one short first period
    always_comb
    begin
        unique case (ctrl_r.clkSel)
            CS_DIV1:    tick = 1'b1;
            CS_DIV8:    tick = (pre_r & PRE_MASK8) == PRE_MASK8;
            CS_DIV64:   tick = (pre_r & PRE_MASK64) == PRE_MASK64;
            CS_DIV256:  tick = (pre_r & PRE_MASK256) == PRE_MASK256;
            CS_DIV1024: tick = (pre_r & PRE_MASK1024) == PRE_MASK1024;
            default:    tick = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // counter sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cnt_r   <= CNT_BOTTOM;
            dirUp_r <= 1'b1;
        end
        else if (wrEn && wb_adr_i == COUNT_OFS)
            cnt_r <= merge16(cnt_r, wb_dat_i, wb_sel_i);
        else if (tick && isFast)
        begin
            // a TOP below the count is missed and the count wraps at full scale
            cnt_r   <= atTop ? CNT_BOTTOM : cnt_r + CNT_STEP;
            dirUp_r <= 1'b1;
        end
        else if (tick && isPc)
        begin
            if (dirUp_r && atTop)
            begin
                dirUp_r <= 1'b0;
                cnt_r   <= cnt_r - CNT_STEP;
            end
            else if (dirUp_r)
                cnt_r <= cnt_r + CNT_STEP;
            else if (atBot)
            begin
                dirUp_r <= 1'b1;
                cnt_r   <= cnt_r + CNT_STEP;
            end
            else
                cnt_r <= cnt_r - CNT_STEP;
        end
    end

    // ----------------------------------------------------------------
    // control, capture-top and compare buffers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ctrl_r    <= CTRL_RESET;
            capTop_r  <= '0;
            ocrABuf_r <= '0;
            ocrBBuf_r <= '0;
        end
        else if (wrEn)
        begin
            unique case (wb_adr_i)
                CTRL_OFS:   ctrl_r    <= ctrl_s'(ctrlMerged[CTRL_W-1:0]);
                CAPTOP_OFS: capTop_r  <= merge16(capTop_r, wb_dat_i, wb_sel_i);
                CMPA_OFS:   ocrABuf_r <= merge16(ocrABuf_r, wb_dat_i, wb_sel_i) & fixMask;
                CMPB_OFS:   ocrBBuf_r <= merge16(ocrBBuf_r, wb_dat_i, wb_sel_i) & fixMask;
                default:    ;
            endcase
        end
    end

    // active compare values: double buffered in the PWM modes only
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ocrAAct_r <= '0;
            ocrBAct_r <= '0;
        end
        else if (loadPt || !(isFast || isPc))
        begin
            ocrAAct_r <= ocrABuf_r;
            ocrBAct_r <= ocrBBuf_r;
        end
    end

    // ----------------------------------------------------------------
    // flags: hardware set wins over a software clear
    // ----------------------------------------------------------------
    always_comb
    begin
        flagSet          = '0;
        flagSet[ST_OVF]  = tick && ((isFast && atTop) || (isPc && atBot));
        flagSet[ST_CMPA] = tick && (isFast || isPc) && (matchA || (atTop && topIsA));
        flagSet[ST_CMPB] = tick && (isFast || isPc) && matchB;
        flagSet[ST_CAP]  = loadPt && topIsCap;
        flagClr          = (wrEn && wb_adr_i == STATUS_OFS && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            flags_r <= '0;
        else
            flags_r <= (flags_r & ~flagClr) | flagSet;
    end

    // ----------------------------------------------------------------
    // compare output units
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            outA_r <= 1'b0;
            outB_r <= 1'b0;
        end
        else if (tick)
        begin
            outA_r <= nextOut(outA_r, ctrl_r.comA, matchA, topIsA, isFast, isPc, atTop, atBot, dirUp_r);
            outB_r <= nextOut(outB_r, ctrl_r.comB, matchB, 1'b0, isFast, isPc, atTop, atBot, dirUp_r);
        end
    end

    // pin override follows the output mode field; register keeps outputs glitch free
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ovrA_r <= 1'b0;
            ovrB_r <= 1'b0;
        end
        else
        begin
            ovrA_r <= (ctrl_r.comA != COM_OFF);
            ovrB_r <= (ctrl_r.comB != COM_OFF);
        end
    end

    // ----------------------------------------------------------------
    // wishbone slave: one wait state, unmapped reads give zero
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ack_r  <= 1'b0;
            rdat_r <= '0;
        end
        else
        begin
            ack_r  <= access;
            rdat_r <= '0;
            if (access && !wb_we_i)
            begin
                unique case (wb_adr_i)
                    CTRL_OFS:   rdat_r <= {21'h0, ctrl_r};
                    CMPA_OFS:   rdat_r <= {16'h0000, ocrABuf_r};
                    CMPB_OFS:   rdat_r <= {16'h0000, ocrBBuf_r};
                    CAPTOP_OFS: rdat_r <= {16'h0000, capTop_r};
                    COUNT_OFS:  rdat_r <= {16'h0000, cnt_r};
                    STATUS_OFS: rdat_r <= {22'h0, outB_r, outA_r, 4'h0, flags_r};
                    default:    rdat_r <= '0;
                endcase
            end
        end
    end

    assign wb_ack_o       = ack_r;
    assign wb_dat_o       = rdat_r;
    assign compareOutputA = outA_r;
    assign compareOutputB = outB_r;
    assign pinOverrideA   = ovrA_r;
    assign pinOverrideB   = ovrB_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    logic cntWr;
    assign cntWr = wrEn && wb_adr_i == COUNT_OFS;

    fastWrap_a: assert property (@(posedge core_clk) disable iff (rst)
        tick && isFast && atTop && !cntWr |=> cnt_r == CNT_BOTTOM)
        else $error("fast counter did not clear after TOP");
    fastCount_a: assert property (@(posedge core_clk) disable iff (rst)
        tick && isFast && !atTop && !cntWr |=> cnt_r == $past(cnt_r) + CNT_STEP)
        else $error("fast counter did not step up");
    pcTurn_a: assert property (@(posedge core_clk) disable iff (rst)
        tick && isPc && dirUp_r && atTop && !cntWr |=> cnt_r == $past(cnt_r) - CNT_STEP && !dirUp_r)
        else $error("phase counter did not turn at TOP");
    ovfFast_a: assert property (@(posedge core_clk) disable iff (rst)
        tick && isFast && atTop |=> flags_r[ST_OVF])
        else $error("overflow flag missing at fast TOP");
    ovfPc_a: assert property (@(posedge core_clk) disable iff (rst)
        tick && isPc && atBot |=> flags_r[ST_OVF])
        else $error("overflow flag missing at phase bottom");
    bufLoad_a: assert property (@(posedge core_clk) disable iff (rst)
        tick && isFast && atTop |=> ocrAAct_r == $past(ocrABuf_r))
        else $error("compare A not loaded at TOP");
    matchFlag_a: assert property (@(posedge core_clk) disable iff (rst)
        tick && (isFast || isPc) && matchB |=> flags_r[ST_CMPB])
        else $error("compare B flag missing on match");
    fastClear_a: assert property (@(posedge core_clk) disable iff (rst)
        tick && isFast && ctrl_r.comA == COM_NONINV && matchA && !atTop |=> !outA_r)
        else $error("non-inverted output not cleared on match");
    tickOnly_a: assert property (@(posedge core_clk) disable iff (rst)
        !tick && !cntWr |=> $stable(cnt_r) && $stable(outA_r))
        else $error("counter or output moved without a tick");
    comOff_a: assert property (@(posedge core_clk) disable iff (rst)
        ctrl_r.comB == COM_OFF |=> outB_r == $past(outB_r))
        else $error("output changed with mode field zero");
    resetOut_a: assert property (@(posedge core_clk)
        rst |=> !outA_r && !outB_r)
        else $error("output state not cleared by reset");

    fastWrapSeen_c: cover property (@(posedge core_clk) disable iff (rst) tick && isFast && atTop);
    pcTurnSeen_c: cover property (@(posedge core_clk) disable iff (rst) tick && isPc && dirUp_r && atTop);
    toggleSeen_c: cover property (@(posedge core_clk) disable iff (rst)
        tick && topIsA && ctrl_r.comA == COM_TOGGLE && matchA);
    spikeSeen_c: cover property (@(posedge core_clk) disable iff (rst)
        tick && isFast && ocrBAct_r == CNT_BOTTOM && ctrl_r.comB == COM_NONINV && atBot);

endmodule : timer16_fast_phase_pwm

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
    import timer16_pwm_pkg::*;

    logic        core_clk;
    logic        rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic        ack;
    logic        outA;
    logic        outB;
    logic        ovA;
    logic        ovB;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] datI;
    logic [31:0] datO;
    logic [31:0] highCnt;
    logic        measB;
    logic [31:0] rdExp[$];
    logic [31:0] rdMask[$];
    logic [31:0] pwmExp[$];
    int          errorCnt;
    int          nCompared;
    int          seed;
    int          measCnt;
    int          i;
    int          top;
    int          cmp;
    logic [3:0]  fixMode[6] = '{MODE_FAST8, MODE_FAST9, MODE_FAST10, MODE_PC8, MODE_PC9, MODE_PC10};
    int          fixTop[6]  = '{255, 511, 1023, 255, 511, 1023};
    int          divs[6]    = '{1, 1, 8, 64, 256, 1024};

    timer16_fast_phase_pwm timer16_fast_phase_pwm_i (
        .core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
        .compareOutputA(outA), .compareOutputB(outB), .pinOverrideA(ovA), .pinOverrideB(ovB));

    // 20 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finishTest();
        $display("compared %0d, mismatches %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finishTest

    // high ticks per counter period; whole periods make the count phase independent
    function automatic int expHigh(input logic fast, input logic inv, input int t, input int c);
        int p;
        int h;
        p = fast ? t + 1 : 2 * t;
        h = fast ? c + 1 : 2 * c;
        return inv ? p - h : h;
    endfunction : expHigh

    // ----------------------------------------------------------------
    // bus and waveform drivers
    // ----------------------------------------------------------------
    task automatic wbCycle(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        datI <= d;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            errorCnt++;
            finishTest();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wbCycle

    task automatic wbRead(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
        rdExp.push_back(exp);
        rdMask.push_back(mask);
        wbCycle(a, 1'b0, 32'h0);
    endtask : wbRead

    task automatic ctl(input logic [3:0] mode, input logic [1:0] com, input logic [2:0] cs);
        wbCycle(CTRL_OFS, 1'b1, {21'h0, cs, com, com, mode});
    endtask : ctl

    // load while stopped; counter cleared so a small TOP never forces a full wrap
    task automatic cfg(input logic [3:0] mode, input logic [1:0] com, input logic [2:0] cs, input int t, input int c);
        ctl(mode, com, CS_STOP);
        wbCycle(COUNT_OFS, 1'b1, 32'h0);
        wbCycle(CAPTOP_OFS, 1'b1, 32'(t));
        wbCycle(CMPA_OFS, 1'b1, 32'(c));
        wbCycle(CMPB_OFS, 1'b1, 32'(c));
        ctl(mode, com, cs);
    endtask : cfg

    task automatic pwm(input logic [3:0] mode, input logic fast, input logic [1:0] com, input logic [2:0] cs,
                       input int n, input int t, input int c, input logic b);
        int p;
        int k;
        logic [31:0] e;
        p = (fast ? t + 1 : 2 * t) * n;
        cfg(mode, com, cs, t, c);
        repeat (2 * p) @(posedge core_clk);
        check(32'(b ? ovB : ovA), 32'(com != COM_OFF));
        e = (com == COM_OFF) ? 32'(2 * p) : (com == COM_TOGGLE) ? 32'(p) : 32'(2 * n * expHigh(fast, com == COM_INV, t, c));
        pwmExp.push_back(e);
        @(posedge core_clk);
        measB   = b;
        highCnt = '0;
        measCnt = 2 * p;
        for (k = 0; k < 2 * p + 4 && measCnt > 0; k++)
            @(posedge core_clk);
        if (measCnt > 0)
        begin
            errorCnt++;
            finishTest();
        end
        $display("test pwm mode %0d com %0d done", mode, com);
    endtask : pwm

    task automatic runFor(input logic [3:0] mode, input int cycles);
        ctl(mode, COM_NONINV, CS_DIV1);
        repeat (cycles) @(posedge core_clk);
        ctl(mode, COM_NONINV, CS_STOP);
    endtask : runFor

    // watcher: read data against the oldest note, duty counts at window end
    always @(posedge core_clk)
    begin
        if (ack === 1'b1 && we === 1'b0 && rdExp.size() > 0)
            check(datO & rdMask.pop_front(), rdExp.pop_front());
        if (measCnt > 0)
        begin
            highCnt = highCnt + 32'(measB ? outB : outA);
            measCnt = measCnt - 1;
            if (measCnt == 0)
                check(highCnt, pwmExp.pop_front());
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        seed = 10;
        {cyc, stb, we, measB, measCnt, errorCnt, nCompared} = '0;
        adr = 8'h00;
        sel = 4'h3;
        datI = 32'h0;
        highCnt = '0;
        rst = 1'b1;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        check({30'h0, outB, outA}, 32'h0);
        wbCycle(8'h18, 1'b1, 32'hffff);
        wbRead(8'h18, 32'h0, '1);
        wbRead(STATUS_OFS, 32'h0, '1);
        $display("test reset done");
        for (i = 0; i < 3; i++)
        begin
            ctl(fixMode[i], COM_OFF, CS_STOP);
            wbCycle(CMPA_OFS, 1'b1, 32'hffff);
            wbRead(CMPA_OFS, 32'(fixTop[i]), '1);
        end
        for (i = 0; i < 6; i++)
            pwm(fixMode[i], i < 3, COM_NONINV, CS_DIV1, 1, fixTop[i], fixTop[i] / 2, i[0]);
        for (i = 0; i < 12; i++)
        begin
            top = 3 + ($random(seed) & 15);
            cmp = (i % 3 == 0) ? 0 : (i % 3 == 1) ? top : (($random(seed) & 255) % (top + 1));
            pwm(i < 6 ? MODE_FASTCAP : MODE_PCCAP, i < 6, i[0] ? COM_INV : COM_NONINV, CS_DIV1, 1, top, cmp, i[1]);
        end
        pwm(MODE_FASTCAP, 1'b1, COM_NONINV, CS_DIV1, 1, 7, 7, 1'b0);
        pwm(MODE_FASTCAP, 1'b1, COM_OFF, CS_DIV1, 1, 7, 3, 1'b0);
        pwm(MODE_FASTCMPA, 1'b1, COM_TOGGLE, CS_DIV1, 1, 7, 7, 1'b0);
        pwm(MODE_PCCMPA, 1'b0, COM_TOGGLE, CS_DIV1, 1, 7, 7, 1'b0);
        for (i = 1; i < 6; i++)
            pwm(MODE_FASTCAP, 1'b1, COM_NONINV, 3'(i), divs[i], 7, 1, 1'b0);
        // flags: nothing while stopped, then the mode's full set after running
        for (i = 0; i < 2; i++)
        begin
            cfg(i ? MODE_PCCMPA : MODE_FASTCAP, COM_NONINV, CS_STOP, 7, 7);
            wbCycle(STATUS_OFS, 1'b1, 32'hf);
            repeat (40) @(posedge core_clk);
            wbRead(STATUS_OFS, 32'h0, 32'hf);
            runFor(i ? MODE_PCCMPA : MODE_FASTCAP, 40);
            wbRead(STATUS_OFS, i ? 32'h307 : 32'h30f, 32'h30f);
        end
        $display("test flags done");
        // count above an unbuffered TOP misses it and wraps through the maximum
        cfg(MODE_FASTCAP, COM_NONINV, CS_STOP, 7, 2);
        wbCycle(COUNT_OFS, 1'b1, 32'hfff0);
        runFor(MODE_FASTCAP, 60);
        wbRead(COUNT_OFS, 32'h0, 32'hfff8);
        wbCycle(COUNT_OFS, 1'b1, 32'h000a);
        runFor(MODE_FASTCAP, 60);
        wbRead(COUNT_OFS, 32'h40, 32'hffc0);
        repeat (4) @(posedge core_clk);
        $display("test top wrap done");
        finishTest();
    end

endmodule : testbench
